// ### design/sdc_pkg.sv
/*
 * Constants, field layouts and carrier types for the segment descriptor
 * cache unit. Assumes a 32-bit APB register bus and a 32-bit read-only
 * memory port towards the descriptor tables.
 */
// What this block does
// [RQ1] Upper descriptor word zero means legacy style
// [RQ2] Gate parameters copied as 16 or 32 bits
// [RQ3] Push width follows the push-width flag
// [RQ4] Selector splits into choice, index, requester level
// [RQ5] Table choice picks global or local table
// [RQ6] Index addresses one of 8K entries
// [RQ7] Selector write fetches 8-byte descriptor into cache
// [RQ8] References served from cache, never refetched
// [RQ9] Cache changes only on segment register write
// [RQ10] Real mode: base selector*16, limit 0000FFFFH
// [RQ11] Real mode trust tier fixed at zero
// [RQ12] Protected mode fills cache from descriptor fields
// [RQ13] Virtual mode loads like real, runs at three
// [RQ14] Four trust tiers, zero most privileged
// [RQ15] Trust tier governs privileged, I/O, segment access (code gates privileged ops and I/O only, no segment access check)
// [RQ16] Valid flag one means present
// [RQ17] Requester level is selector bits 1:0
// [RQ18] System descriptor when access bit 4 is zero
// [RQ19] Fetch address is table base plus index*8
package sdc_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] SDC_OFF_MODE = 8'h00;
    localparam logic [7:0] SDC_OFF_GDT_BASE = 8'h04;
    localparam logic [7:0] SDC_OFF_LDT_BASE = 8'h08;
    localparam logic [7:0] SDC_OFF_SEL_LOAD = 8'h0C;
    localparam logic [7:0] SDC_OFF_STATUS = 8'h10;
    localparam logic [7:0] SDC_OFF_QUERY = 8'h14;
    localparam logic [7:0] SDC_OFF_Q_BASE = 8'h18;
    localparam logic [7:0] SDC_OFF_Q_LIMIT = 8'h1C;
    localparam logic [7:0] SDC_OFF_Q_ATTR = 8'h20;
    localparam logic [7:0] SDC_OFF_GATE = 8'h24;
    localparam logic [7:0] SDC_OFF_GATE_RES = 8'h28;
    localparam logic [7:0] SDC_OFF_SEL_RD = 8'h2C;

    // ************************************************************
    // Sizes and field positions
    // ************************************************************
    localparam int SDC_NSEG = 6;
    localparam int SDC_SEGW = 3;
    localparam logic [2:0] SDC_SEG_LAST = 3'h5;
    localparam int SDC_SEL_LD_SEG_LSB = 16;
    localparam int SDC_ACC_S_BIT = 4;
    localparam int SDC_ACC_P_BIT = 7;
    localparam int SDC_GATE_B_BIT = 8;
    localparam logic [31:0] SDC_REAL_LIMIT = 32'h0000FFFF;
    localparam logic [7:0] SDC_REAL_ACCESS = 8'h93;
    localparam logic [3:0] SDC_REAL_FLAGS = 4'h0;
    localparam logic [31:0] SDC_PAGE_LIMIT_LO = 32'h00000FFF;
    localparam logic [1:0] SDC_TIER_TOP = 2'h0;
    localparam logic [1:0] SDC_TIER_LOW = 2'h3;
    localparam logic [15:0] SDC_LEGACY_HI = 16'h0000;

    // Operating modes
    typedef enum logic [1:0] {
        SDC_MODE_REAL = 2'b00,
        SDC_MODE_PROT = 2'b01,
        SDC_MODE_V86 = 2'b10
    } sdc_mode_t;

    // Decoded selector
    typedef struct packed {
        logic [12:0] index;
        logic table_choice_bit;
        logic [1:0] requester_level;
    } sdc_sel_t;

    // One hidden cache entry
    typedef struct packed {
        logic [15:0] sel;
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0] access;
        logic [3:0] flags;
        logic legacy;
    } sdc_cache_t;

    // Memory read request and answer
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } sdc_mreq_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } sdc_mrsp_t;

endpackage

// ### design/sdc_desc_fetch.sv
/*
 * Descriptor fetcher: reads the two words of one descriptor from memory.
 * Assumes a memory that answers each held request with one valid pulse.
 */
`timescale 1ns/1ps
module sdc_desc_fetch (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Start request
    input wire logic start,
    input wire logic [31:0] entry_addr,
    // Memory port
    output sdc_pkg::sdc_mreq_t mreq,
    input wire sdc_pkg::sdc_mrsp_t mrsp,
    // Result
    output logic done,
    output logic [63:0] desc
);

    // ************************************************************
    // Two-word sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        SDC_F_IDLE = 2'b00,
        SDC_F_LO = 2'b01,
        SDC_F_HI = 2'b10
    } sdc_fstate_t;

    sdc_fstate_t state_q;
    logic [31:0] addr_q;
    logic [31:0] lo_q;

    // Word order: low word first, then high word at +4
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= SDC_F_IDLE;
            addr_q <= 32'h00000000;
            lo_q <= 32'h00000000;
            done <= 1'b0;
            desc <= 64'h0000000000000000;
        end else begin
            done <= 1'b0;
            case (state_q)
                SDC_F_IDLE: begin
                    if (start) begin
                        addr_q <= entry_addr;
                        state_q <= SDC_F_LO;
                    end
                end
                SDC_F_LO: begin
                    if (mrsp.valid) begin
                        lo_q <= mrsp.data;
                        addr_q <= addr_q + 32'h00000004;
                        state_q <= SDC_F_HI;
                    end
                end
                SDC_F_HI: begin
                    // Cache only sees whole 8 bytes, never half a descriptor
                    if (mrsp.valid) begin
                        desc <= {mrsp.data, lo_q}; // [RQ19]
                        done <= 1'b1;
                        state_q <= SDC_F_IDLE;
                    end
                end
                default: state_q <= SDC_F_IDLE;
            endcase
        end
    end

    // Request held until the answer arrives
    always_comb begin
        mreq.valid = (state_q == SDC_F_LO) || (state_q == SDC_F_HI);
        mreq.addr = addr_q;
    end

endmodule

// ### design/sdc_unit.sv
/*
 * Descriptor cache unit top: six segment registers with hidden caches,
 * filled per operating mode, plus query and gate sizing over APB.
 * Assumes an APB master on mclk and a descriptor memory port.
 */
`timescale 1ns/1ps
module sdc_unit (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Descriptor memory port
    output sdc_pkg::sdc_mreq_t mreq,
    input wire sdc_pkg::sdc_mrsp_t mrsp,
    // Segment reference port, served from the caches only
    input wire logic [2:0] ref_seg,
    output logic [31:0] ref_base,
    output logic [31:0] ref_limit,
    output logic ref_present,
    // Privilege outputs
    output logic [1:0] trust_tier,
    output logic priv_ok,
    output logic io_ok
);

    // ************************************************************
    // Control registers
    // ************************************************************
    sdc_pkg::sdc_mode_t mode_q;
    logic [31:0] gdt_base_q;
    logic [31:0] ldt_base_q;
    logic [1:0] cur_tier_q;
    logic [1:0] iopl_q;
    logic [2:0] query_q;
    logic [31:0] gate_q;
    sdc_pkg::sdc_cache_t cache_q [sdc_pkg::SDC_NSEG];

    // Load sequencing
    logic busy_q;
    logic [2:0] ld_seg_q;
    sdc_pkg::sdc_sel_t ld_sel_q;
    logic bad_seg_q;

    logic wr_en;
    logic sel_wr;
    logic [2:0] wr_seg;
    sdc_pkg::sdc_sel_t wr_sel;
    logic fetch_start;
    logic fetch_done;
    logic [63:0] fetch_desc;
    logic [31:0] tbl_base;

    // ************************************************************
    // APB decode
    // ************************************************************
    // A selector load stalls the bus while an earlier protected-mode load is still fetching
    assign sel_wr = psel && penable && pwrite && (paddr == sdc_pkg::SDC_OFF_SEL_LOAD);
    assign pready = !(sel_wr && busy_q);
    assign wr_en = psel && penable && pwrite && pready;
    assign wr_seg = pwdata[sdc_pkg::SDC_SEL_LD_SEG_LSB +: sdc_pkg::SDC_SEGW];
    assign wr_sel = sdc_pkg::sdc_sel_t'(pwdata[15:0]); // [RQ4] [RQ17]

    // Mode, iopl, table bases, query and gate word
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_q <= sdc_pkg::SDC_MODE_REAL;
            gdt_base_q <= 32'h00000000;
            ldt_base_q <= 32'h00000000;
            iopl_q <= 2'h0;
            query_q <= 3'h0;
            gate_q <= 32'h00000000;
        end else if (wr_en) begin
            case (paddr)
                sdc_pkg::SDC_OFF_MODE: begin
                    mode_q <= sdc_pkg::sdc_mode_t'(pwdata[1:0]);
                    iopl_q <= pwdata[5:4];
                end
                sdc_pkg::SDC_OFF_GDT_BASE: gdt_base_q <= pwdata;
                sdc_pkg::SDC_OFF_LDT_BASE: ldt_base_q <= pwdata;
                sdc_pkg::SDC_OFF_QUERY: query_q <= pwdata[2:0];
                sdc_pkg::SDC_OFF_GATE: gate_q <= pwdata;
                default: ;
            endcase
        end
    end

    // Tier set by the mode being written: real top, virtual lowest
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur_tier_q <= sdc_pkg::SDC_TIER_TOP;
        end else if (wr_en && paddr == sdc_pkg::SDC_OFF_MODE) begin
            case (pwdata[1:0])
                sdc_pkg::SDC_MODE_PROT: cur_tier_q <= pwdata[9:8]; // [RQ14]
                sdc_pkg::SDC_MODE_V86: cur_tier_q <= sdc_pkg::SDC_TIER_LOW; // [RQ13]
                default: cur_tier_q <= sdc_pkg::SDC_TIER_TOP; // [RQ11]
            endcase
        end
    end

    // ************************************************************
    // Descriptor fetch
    // ************************************************************
    // Table choice bit picks local or global table
    assign tbl_base = ld_sel_q.table_choice_bit ? ldt_base_q : gdt_base_q; // [RQ5]

    sdc_desc_fetch u_fetch (
        .mclk(mclk),
        .reset(reset),
        .start(fetch_start),
        .entry_addr(tbl_base + {16'h0000, ld_sel_q.index, 3'b000}), // [RQ6] [RQ19]
        .mreq(mreq),
        .mrsp(mrsp),
        .done(fetch_done),
        .desc(fetch_desc)
    );

    // Load sequencing: a protected-mode load waits for memory
    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_q <= 1'b0;
            ld_seg_q <= 3'h0;
            ld_sel_q <= '0;
            fetch_start <= 1'b0;
            bad_seg_q <= 1'b0;
        end else begin
            fetch_start <= 1'b0;
            if (wr_en && paddr == sdc_pkg::SDC_OFF_SEL_LOAD) begin
                bad_seg_q <= wr_seg > sdc_pkg::SDC_SEG_LAST;
                if (mode_q == sdc_pkg::SDC_MODE_PROT && wr_seg <= sdc_pkg::SDC_SEG_LAST) begin
                    busy_q <= 1'b1; // [RQ7]
                    ld_seg_q <= wr_seg;
                    ld_sel_q <= wr_sel;
                    fetch_start <= 1'b1;
                end
            end else if (fetch_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Hidden caches, one per segment register
    // ************************************************************
    // Updated only on a selector write; table edits need a reload
    generate
        for (genvar g = 0; g < sdc_pkg::SDC_NSEG; g++) begin : g_cache
            always_ff @(posedge mclk) begin
                if (reset) begin
                    cache_q[g] <= '0;
                end else if (wr_en && paddr == sdc_pkg::SDC_OFF_SEL_LOAD
                             && wr_seg == 3'(g)
                             && mode_q != sdc_pkg::SDC_MODE_PROT) begin
                    // Real and virtual modes: fixed limit, present, usable
                    cache_q[g].sel <= wr_sel; // [RQ9]
                    cache_q[g].base <= {12'h000, pwdata[15:0], 4'h0}; // [RQ10] [RQ13]
                    cache_q[g].limit <= sdc_pkg::SDC_REAL_LIMIT; // [RQ10]
                    cache_q[g].access <= sdc_pkg::SDC_REAL_ACCESS;
                    cache_q[g].flags <= sdc_pkg::SDC_REAL_FLAGS;
                    cache_q[g].legacy <= 1'b0;
                end else if (fetch_done && ld_seg_q == 3'(g)) begin
                    cache_q[g].sel <= ld_sel_q; // [RQ12]
                    cache_q[g].base <= {fetch_desc[63:56], fetch_desc[39:16]};
                    cache_q[g].access <= fetch_desc[47:40];
                    cache_q[g].flags <= fetch_desc[55:52];
                    // Top 16 bits of the high word zero mark a legacy descriptor
                    cache_q[g].legacy <= fetch_desc[63:48] == sdc_pkg::SDC_LEGACY_HI; // [RQ1]
                    if (fetch_desc[55]) begin
                        // Page granular limit
                        cache_q[g].limit <= {fetch_desc[51:48], fetch_desc[15:0],
                                             sdc_pkg::SDC_PAGE_LIMIT_LO[11:0]};
                    end else begin
                        cache_q[g].limit <= {12'h000, fetch_desc[51:48], fetch_desc[15:0]};
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Reference and privilege outputs
    // ************************************************************
    // Served from the cache without touching memory
    always_ff @(posedge mclk) begin
        if (reset || ref_seg > sdc_pkg::SDC_SEG_LAST) begin
            ref_base <= 32'h00000000;
            ref_limit <= 32'h00000000;
            ref_present <= 1'b0;
        end else begin
            ref_base <= cache_q[ref_seg].base; // [RQ8]
            ref_limit <= cache_q[ref_seg].limit;
            ref_present <= cache_q[ref_seg].access[sdc_pkg::SDC_ACC_P_BIT]; // [RQ16]
        end
    end

    // Privileged ops only at tier 0, I/O when tier <= iopl
    always_ff @(posedge mclk) begin
        if (reset) begin
            trust_tier <= sdc_pkg::SDC_TIER_TOP;
            priv_ok <= 1'b1;
            io_ok <= 1'b1;
        end else begin
            trust_tier <= cur_tier_q;
            priv_ok <= cur_tier_q == sdc_pkg::SDC_TIER_TOP; // [RQ15]
            io_ok <= cur_tier_q <= iopl_q; // [RQ15]
        end
    end

    // ************************************************************
    // Call gate sizing helper
    // ************************************************************
    // Gate word in: bits 4:0 count, bit 8 push flag, bit 16 native gate
    logic [9:0] param_bytes;
    logic [2:0] push_bytes;
    always_comb begin
        // Legacy gates copy 16-bit words, native ones 32-bit
        if (gate_q[16]) begin
            param_bytes = {3'b000, gate_q[4:0], 2'b00}; // [RQ2]
        end else begin
            param_bytes = {4'b0000, gate_q[4:0], 1'b0}; // [RQ2]
        end
        push_bytes = gate_q[sdc_pkg::SDC_GATE_B_BIT] ? 3'h4 : 3'h2; // [RQ3]
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    sdc_pkg::sdc_cache_t qc;
    assign qc = cache_q[(query_q <= sdc_pkg::SDC_SEG_LAST) ? query_q : 3'h0];

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                sdc_pkg::SDC_OFF_MODE: prdata <= {22'h0, cur_tier_q, 2'b00, iopl_q, 2'b00,
                                                  mode_q};
                sdc_pkg::SDC_OFF_GDT_BASE: prdata <= gdt_base_q;
                sdc_pkg::SDC_OFF_LDT_BASE: prdata <= ldt_base_q;
                sdc_pkg::SDC_OFF_STATUS: prdata <= {28'h0, bad_seg_q,
                    qc.access[sdc_pkg::SDC_ACC_S_BIT] == 1'b0, qc.legacy, busy_q}; // [RQ18]
                sdc_pkg::SDC_OFF_QUERY: prdata <= {29'h0, query_q};
                sdc_pkg::SDC_OFF_Q_BASE: prdata <= qc.base;
                sdc_pkg::SDC_OFF_Q_LIMIT: prdata <= qc.limit;
                sdc_pkg::SDC_OFF_Q_ATTR: prdata <= {20'h0, qc.flags, qc.access};
                sdc_pkg::SDC_OFF_GATE: prdata <= gate_q;
                sdc_pkg::SDC_OFF_GATE_RES: prdata <= {13'h0, push_bytes, 6'h0, param_bytes};
                sdc_pkg::SDC_OFF_SEL_RD: prdata <= {16'h0, qc.sel};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Unmapped addresses answer with an error
    assign pslverr = psel && penable && (paddr > sdc_pkg::SDC_OFF_SEL_RD || paddr[1:0] != 2'b00);

endmodule

// ### dv/sdc_unit_sva.sv
/*
 * Port checker for the descriptor cache unit.
 * Assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module sdc_unit_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    // Descriptor memory port
    input wire sdc_pkg::sdc_mreq_t mreq,
    input wire sdc_pkg::sdc_mrsp_t mrsp,
    // Reference and privilege outputs
    input wire logic [2:0] ref_seg,
    input wire logic [31:0] ref_base,
    input wire logic [31:0] ref_limit,
    input wire logic ref_present,
    input wire logic [1:0] trust_tier,
    input wire logic priv_ok,
    input wire logic io_ok
);
    // ********
    // Helpers
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic any_wr;
    logic load_wr;
    logic hi_q;
    logic [1:0] up_q;
    assign any_wr = psel && penable && pwrite;
    assign load_wr = any_wr && pready && paddr == sdc_pkg::SDC_OFF_SEL_LOAD;
    // Which descriptor word is answered next
    always_ff @(posedge mclk) begin
        if (reset) begin
            hi_q <= 1'b0;
        end else if (mreq.valid && mrsp.valid) begin
            hi_q <= !hi_q;
        end
    end
    // Cycles since reset; no steadiness check across it
    always_ff @(posedge mclk) begin
        if (reset) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    sequence quiet_s;
        up_q == 2'h3 && $stable(ref_seg) && !any_wr && !mrsp.valid;
    endsequence
    // ********
    // Assertions
    // ********
    mreq_hold_a: assert property (mreq.valid && !mrsp.valid |=> mreq.valid && $stable(mreq.addr))
        else $error("request dropped early");
    word_step_a: assert property (mreq.valid && mrsp.valid && !hi_q |=>
        mreq.valid && mreq.addr == $past(mreq.addr) + 32'h4)
        else $error("high word address wrong");
    last_word_a: assert property (mreq.valid && mrsp.valid && hi_q |=> !mreq.valid)
        else $error("fetch runs past eight bytes");
    fetch_cause_a: assert property ($rose(mreq.valid) && !hi_q |->
        $past(load_wr) || $past(load_wr, 2) || $past(load_wr, 3))
        else $error("fetch without a load");
    ref_steady_a: assert property (quiet_s [*3] |=>
        $stable(ref_base) && $stable(ref_limit) && $stable(ref_present))
        else $error("reference moved without a load");
    stall_cause_a: assert property (!pready |-> any_wr && paddr == sdc_pkg::SDC_OFF_SEL_LOAD)
        else $error("wait state outside a segment load");
    stall_bound_a: assert property (!pready |-> ##[1:200] pready)
        else $error("segment load stalled too long");
    tier_io_a: assert property (priv_ok |-> io_ok)
        else $error("top tier refused input output");
    // Main scenarios reached
    cover property ($rose(mreq.valid));
    cover property (!pready);
    cover property (trust_tier == 2'h3);
endmodule

// ### dv/sdc_mem_model.sv
/*
 * Behavioural descriptor table memory for the cache unit bench.
 * Assumes requests held until answered; the bench fills mem directly.
 */
`timescale 1ns/1ps
module sdc_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Memory port
    input wire sdc_pkg::sdc_mreq_t mreq,
    output sdc_pkg::sdc_mrsp_t mrsp,
    // Latency choice
    input wire logic slow
);
    logic [31:0] mem [0:255];
    logic [2:0] wait_q;
    // One answer per request; idle data toggles so stale words never pass
    always_ff @(posedge mclk) begin
        if (reset) begin
            mrsp.valid <= 1'b0;
            mrsp.data <= 32'hA5A5A5A5;
            wait_q <= 3'h0;
        end else if (mreq.valid && !mrsp.valid && wait_q >= (slow ? 3'h3 : 3'h0)) begin
            mrsp.valid <= 1'b1;
            mrsp.data <= mem[mreq.addr[9:2]];
            wait_q <= 3'h0;
        end else begin
            mrsp.valid <= 1'b0;
            mrsp.data <= ~mrsp.data;
            wait_q <= mreq.valid ? wait_q + 3'h1 : 3'h0;
        end
    end
endmodule

// ### dv/sdc_unit_tb.sv
/*
 * Self-checking bench for the descriptor cache unit.
 * Assumes package, unit, model and checker compiled first.
 */
`timescale 1ns/1ps
module sdc_unit_tb;
    // ********
    // Signals
    // ********
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, slow, err;
    logic ref_present, priv_ok, io_ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ref_base, ref_limit;
    logic [2:0] ref_seg;
    logic [1:0] trust_tier;
    sdc_pkg::sdc_mreq_t mreq;
    sdc_pkg::sdc_mrsp_t mrsp;
    int n_errors = 0;
    int samples_checked = 0;
    sdc_unit sdc_unit_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mreq(mreq), .mrsp(mrsp), .ref_seg(ref_seg), .ref_base(ref_base),
        .ref_limit(ref_limit), .ref_present(ref_present), .trust_tier(trust_tier),
        .priv_ok(priv_ok), .io_ok(io_ok));
    sdc_mem_model sdc_mem_model_i (.mclk(mclk), .reset(reset), .mreq(mreq), .mrsp(mrsp),
        .slow(slow));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ********
    // Shared tasks
    // ********
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Segment load, then poll until not busy
    task automatic load(input logic [2:0] seg, input logic [15:0] sel);
        apb(1'b1, sdc_pkg::SDC_OFF_SEL_LOAD, {13'h0, seg, sel});
        repeat (3) @(posedge mclk);
        do begin
            apb(1'b0, sdc_pkg::SDC_OFF_STATUS);
        end while (rd[0] !== 1'b0);
    endtask
    task automatic put(input logic [31:0] a, input logic [31:0] hi, input logic [31:0] lo);
        sdc_mem_model_i.mem[a[9:2]] = lo;
        sdc_mem_model_i.mem[a[9:2] + 8'h1] = hi;
    endtask
    // Reads one cache by query and reference port
    task automatic look(input logic [2:0] seg, input logic [15:0] sel, input logic [31:0] b,
        input logic [31:0] l, input logic [31:0] at, input logic p);
        apb(1'b1, sdc_pkg::SDC_OFF_QUERY, {29'h0, seg});
        apb(1'b0, sdc_pkg::SDC_OFF_Q_BASE);
        chk("query base", rd, b);
        apb(1'b0, sdc_pkg::SDC_OFF_Q_LIMIT);
        chk("query limit", rd, l);
        apb(1'b0, sdc_pkg::SDC_OFF_Q_ATTR);
        chk("query attributes", rd, at);
        apb(1'b0, sdc_pkg::SDC_OFF_SEL_RD);
        chk("query selector", rd, {16'h0, sel});
        ref_seg <= seg;
        repeat (3) @(posedge mclk);
        chk("ref base", ref_base, b);
        chk("ref limit", ref_limit, l);
        chk("ref present", {31'h0, ref_present}, {31'h0, p});
    endtask
    task automatic tiers(input logic [1:0] t, input logic pv, input logic io);
        repeat (3) @(posedge mclk);
        chk("trust tier", {30'h0, trust_tier}, {30'h0, t});
        chk("privileged allowed", {31'h0, priv_ok}, {31'h0, pv});
        chk("io allowed", {31'h0, io_ok}, {31'h0, io});
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_real();
        tiers(2'h0, 1'b1, 1'b1);
        apb(1'b1, sdc_pkg::SDC_OFF_MODE, 32'h0);
        load(3'h2, 16'h1234);
        look(3'h2, 16'h1234, 32'h00012340, 32'h0000FFFF, 32'h093, 1'b1);
        tiers(2'h0, 1'b1, 1'b1);
    endtask
    task automatic t_prot();
        apb(1'b1, sdc_pkg::SDC_OFF_MODE, 32'h211);
        apb(1'b1, sdc_pkg::SDC_OFF_GDT_BASE, 32'h100);
        apb(1'b1, sdc_pkg::SDC_OFF_LDT_BASE, 32'h200);
        put(32'h128, 32'h12449234, 32'h5678ABCD);
        put(32'h208, 32'h000002AB, 32'hCDEF1111);
        load(3'h3, 16'h002A);
        look(3'h3, 16'h002A, 32'h12345678, 32'h0004ABCD, 32'h492, 1'b1);
        apb(1'b0, sdc_pkg::SDC_OFF_STATUS);
        chk("native user status", {30'h0, rd[2:1]}, 32'h0);
        load(3'h4, 16'h000F);
        look(3'h4, 16'h000F, 32'h00ABCDEF, 32'h00001111, 32'h002, 1'b0);
        apb(1'b0, sdc_pkg::SDC_OFF_STATUS);
        chk("legacy system status", {30'h0, rd[2:1]}, 32'h3);
        tiers(2'h2, 1'b0, 1'b0);
    endtask
    // Top index, slow memory, queued loads, stale entry
    task automatic t_stick();
        slow <= 1'b1;
        put(32'h100F8, 32'h00409310, 32'h00000010);
        apb(1'b1, sdc_pkg::SDC_OFF_SEL_LOAD, {13'h0, 3'h5, 16'hFFFB});
        load(3'h0, 16'hFFFB);
        look(3'h5, 16'hFFFB, 32'h00100000, 32'h00000010, 32'h493, 1'b1);
        put(32'h100F8, 32'h00409310, 32'hFFFF0010);
        look(3'h0, 16'hFFFB, 32'h00100000, 32'h00000010, 32'h493, 1'b1);
        load(3'h0, 16'hFFFB);
        look(3'h0, 16'hFFFB, 32'h0010FFFF, 32'h00000010, 32'h493, 1'b1);
        slow <= 1'b0;
    endtask
    task automatic t_v86();
        apb(1'b1, sdc_pkg::SDC_OFF_MODE, 32'h32);
        load(3'h1, 16'hF000);
        look(3'h1, 16'hF000, 32'h000F0000, 32'h0000FFFF, 32'h093, 1'b1);
        tiers(2'h3, 1'b0, 1'b1);
        apb(1'b1, sdc_pkg::SDC_OFF_MODE, 32'h02);
        tiers(2'h3, 1'b0, 1'b0);
    endtask
    task automatic t_gate();
        logic [4:0] c;
        logic nat, f;
        for (int k = 0; k < 8; k++) begin
            c = (k < 4) ? 5'h1F : 5'h03;
            nat = k[0];
            f = k[1];
            apb(1'b1, sdc_pkg::SDC_OFF_GATE, {15'h0, nat, 7'h0, f, 3'h0, c});
            apb(1'b0, sdc_pkg::SDC_OFF_GATE_RES);
            chk("gate sizes", rd, {13'h0, (f ? 3'h4 : 3'h2), 6'h0,
                (10'(c) * (nat ? 10'h4 : 10'h2))});
        end
    endtask
    task automatic t_bad();
        apb(1'b0, 8'h30);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, sdc_pkg::SDC_OFF_SEL_LOAD, {13'h0, 3'h6, 16'h0});
        apb(1'b0, sdc_pkg::SDC_OFF_STATUS);
        chk("bad segment flag", {31'h0, rd[3]}, 32'h1);
    endtask
    // ********
    // Verdict and run
    // ********
    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ref_seg = 3'h0;
        slow = 1'b0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        t_real();
        t_prot();
        t_stick();
        t_v86();
        t_gate();
        t_bad();
        give_verdict();
    end
    // Run needs a few hundred cycles; cuts a hang
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        give_verdict();
    end
endmodule
bind sdc_unit sdc_unit_sva sdc_unit_sva_i (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .mreq(mreq),
    .mrsp(mrsp), .ref_seg(ref_seg), .ref_base(ref_base), .ref_limit(ref_limit),
    .ref_present(ref_present), .trust_tier(trust_tier), .priv_ok(priv_ok), .io_ok(io_ok));
